// *** hdl/txcb_map.svh ***
// Register offsets, command and status field positions, reset values
`ifndef TXCB_MAP_SVH
`define TXCB_MAP_SVH
`define TXCB_OFF_CFG      12'h000
`define TXCB_OFF_STAT     12'h004
`define TXCB_OFF_STS_DATA 12'h008
`define TXCB_OFF_STS_USED 12'h00c
`define TXCB_CFG_ALLOW    0
`define TXCB_CFG_DEFCHK   1
`define TXCB_STAT_TXE     0
`define TXCB_STAT_OVR     1
`define TXCB_A_ALN_HI     25
`define TXCB_A_ALN_LO     24
`define TXCB_A_OFF_HI     20
`define TXCB_A_OFF_LO     16
`define TXCB_A_FIRST      13
`define TXCB_A_LAST       12
`define TXCB_A_SIZE_HI    10
`define TXCB_B_TAG_LO     16
`define TXCB_B_NOCRC      13
`define TXCB_B_NOPAD      12
`define TXCB_B_LEN_HI     10
`define TXCB_CFG_RST      2'h0
`define TXCB_RESP_OKAY    2'h0
`define TXCB_RESP_SLVERR  2'h2
`endif

// *** hdl/txcb_pkg.sv ***
// Types shared by the transmit command buffer block
package txcb_pkg;
	typedef enum logic [1:0] {
		txcb_cmda,
		txcb_cmdb,
		txcb_data,
		txcb_emit
	} txcb_state_t;
endpackage

// *** hdl/txcb_top.sv ***
// Transmit command parser, payload byte stripper and transmit status queue
// What this block does
// - Copy command tag into status upper half
// - Command bit 13 disables automatic CRC
// - Bit 12 disables padding, CRC still added
// - Packet length mismatch sets transmit error
// - First two buffer words are commands
// - Offset low bits pick first byte lane
// - Offset upper bits skip whole words
// - Trailing unused bytes never reach MAC
// - Host pads to alignment; device strips it
// - Only payload bytes stored, whole words stripped
// - One status word per packet, own FIFO
// - Full status FIFO suspends transmission
// - Overrun-allow: continue, count zero, block writes
// - Overrun-allow: overrun raises no transmit error
// - Status bit 15 ORs error bits
// - Bits 11,10 report carrier lost/absent
// - Bit 9 reports late collision
// - Bit 8 excessive collisions, 6:3 count
// - Bit 2 excess deferral if enabled; bit 0 deferred
// - Differing second command words set error
// - Accumulated buffer sizes checked against length
// - First command bits 13/12 mark first/last
`timescale 1ns/1ps
`include "txcb_map.svh"

module txcb_top
	import txcb_pkg::*;
#(
	parameter int STS_DEPTH = 16,
	parameter int AW        = 12
) (
	input  wire logic          core_clk,
	input  wire logic          srst,
	input  wire logic [AW-1:0] s_axi_awaddr,
	input  wire logic          s_axi_awvalid,
	output logic               s_axi_awready,
	input  wire logic [31:0]   s_axi_wdata,
	input  wire logic [3:0]    s_axi_wstrb,
	input  wire logic          s_axi_wvalid,
	output logic               s_axi_wready,
	output logic [1:0]         s_axi_bresp,
	output logic               s_axi_bvalid,
	input  wire logic          s_axi_bready,
	input  wire logic [AW-1:0] s_axi_araddr,
	input  wire logic          s_axi_arvalid,
	output logic               s_axi_arready,
	output logic [31:0]        s_axi_rdata,
	output logic [1:0]         s_axi_rresp,
	output logic               s_axi_rvalid,
	input  wire logic          s_axi_rready,
	input  wire logic [31:0]   tx_word,
	input  wire logic          tx_word_valid,
	output logic               tx_word_ready,
	output logic [7:0]         mac_byte,
	output logic               mac_byte_valid,
	output logic               mac_byte_last,
	output logic               mac_no_crc,
	output logic               mac_no_pad,
	input  wire logic          mac_byte_ready,
	input  wire logic          st_valid,
	input  wire logic          st_carrier_lost,
	input  wire logic          st_no_carrier,
	input  wire logic          st_late_collision,
	input  wire logic          st_excess_collisions,
	input  wire logic [3:0]    st_collision_count,
	input  wire logic          st_excess_deferral,
	input  wire logic          st_deferred,
	output logic               transmit_error_flag
);
	localparam int CW = $clog2(STS_DEPTH + 1);
	localparam int PW = (STS_DEPTH > 1) ? $clog2(STS_DEPTH) : 1;

	function automatic logic txcb_mapped(input logic [AW-1:0] a);
		return (a[11:0] == `TXCB_OFF_CFG) || (a[11:0] == `TXCB_OFF_STAT) ||
			(a[11:0] == `TXCB_OFF_STS_DATA) || (a[11:0] == `TXCB_OFF_STS_USED);
	endfunction

	txcb_state_t       state_reg;
	txcb_state_t       state_next;
	logic [31:0]       cmda_reg;
	logic [31:0]       pkt_cmdb_reg;
	logic [11:0]       len_acc_reg;
	logic              in_packet_reg;
	logic [10:0]       widx_reg;
	logic [31:0]       word_reg;
	logic [1:0]        lane_reg;
	logic [1:0]        end_lane_reg;
	logic              word_final_reg;
	logic              buf_done_reg;
	logic [15:0]       sent_tag_reg;
	logic [1:0]        cfg_reg;
	logic              ovr_reg;
	logic [31:0]       sts_mem [STS_DEPTH];
	logic [PW-1:0]     wr_ptr_reg;
	logic [PW-1:0]     rd_ptr_reg;
	logic [CW-1:0]     count_reg;
	logic [AW-1:0]     awaddr_reg;
	logic [31:0]       wdata_reg;
	logic [3:0]        wstrb_reg;

	// Buffer geometry derived from the first command word
	logic [1:0]  lane0;
	logic [2:0]  skipw;
	logic [10:0] bsize;
	logic [12:0] span;
	logic [10:0] payw;
	logic [12:0] full_len;
	logic [12:0] aln_mask;
	logic [12:0] aligned;
	logic [10:0] totw;
	logic [10:0] pay_end;
	logic        accept;
	logic        is_pay;
	logic        last_word;
	logic        emit_step;
	logic        suspend;
	logic [11:0] acc_now;
	logic        err_set;
	logic        err_clr;
	logic        sts_full;
	logic        sts_push;
	logic        sts_pop;
	logic        do_write;
	logic        es_bit;
	logic [31:0] sts_word;

	assign lane0    = cmda_reg[`TXCB_A_OFF_LO+1:`TXCB_A_OFF_LO];
	assign skipw    = cmda_reg[`TXCB_A_OFF_HI:`TXCB_A_OFF_LO+2];
	assign bsize    = cmda_reg[`TXCB_A_SIZE_HI:0];
	assign span     = {2'h0, bsize} + {11'h0, lane0};
	assign payw     = 11'((span + 13'h3) >> 2);
	assign full_len = {8'h0, cmda_reg[`TXCB_A_OFF_HI:`TXCB_A_OFF_LO]} + {2'h0, bsize};
	// Reserved alignment code behaves as 4-byte alignment
	always_comb begin
		unique case (cmda_reg[`TXCB_A_ALN_HI:`TXCB_A_ALN_LO])
			2'h1:    aln_mask = 13'h00f;
			2'h2:    aln_mask = 13'h01f;
			default: aln_mask = 13'h003;
		endcase
	end
	assign aligned   = (full_len + aln_mask) & ~aln_mask;
	assign totw      = aligned[12:2];
	assign pay_end   = {8'h0, skipw} + payw;
	assign accept    = tx_word_valid & tx_word_ready;
	assign is_pay    = (widx_reg >= {8'h0, skipw}) && (widx_reg < pay_end);
	assign last_word = (widx_reg == totw - 11'h1);
	assign emit_step = (state_reg == txcb_emit) && (!mac_byte_valid || mac_byte_ready);
	assign sts_full  = (count_reg == CW'(STS_DEPTH));
	assign suspend   = !in_packet_reg && sts_full && !cfg_reg[`TXCB_CFG_ALLOW];
	assign acc_now   = cmda_reg[`TXCB_A_FIRST] ? {1'b0, bsize} : len_acc_reg + {1'b0, bsize};

	always_comb begin
		state_next = state_reg;
		unique case (state_reg)
			txcb_cmda: if (accept) state_next = txcb_cmdb;
			txcb_cmdb: if (accept) state_next = (totw == 11'h0) ? txcb_cmda : txcb_data;
			txcb_data: begin
				if (accept && is_pay)
					state_next = txcb_emit;
				else if (accept && last_word)
					state_next = txcb_cmda;
			end
			txcb_emit: begin
				if (emit_step && lane_reg == end_lane_reg)
					state_next = buf_done_reg ? txcb_cmda : txcb_data;
			end
		endcase
	end

	always_ff @(posedge core_clk) begin
		if (srst)
			state_reg <= txcb_cmda;
		else
			state_reg <= state_next;
	end

	always_ff @(posedge core_clk) begin
		if (srst)
			tx_word_ready <= 1'b0;
		else
			tx_word_ready <= (state_next != txcb_emit) &&
				!(state_next == txcb_cmda && suspend);
	end

	// Command capture and per-packet consistency tracking
	always_ff @(posedge core_clk) begin
		if (srst) begin
			cmda_reg      <= 32'h0;
			pkt_cmdb_reg  <= 32'h0;
			len_acc_reg   <= 12'h0;
			in_packet_reg <= 1'b0;
		end else if (accept && state_reg == txcb_cmda) begin
			cmda_reg <= tx_word;
			if (tx_word[`TXCB_A_FIRST])
				in_packet_reg <= 1'b1;
		end else if (accept && state_reg == txcb_cmdb) begin
			len_acc_reg <= acc_now;
			if (cmda_reg[`TXCB_A_FIRST])
				pkt_cmdb_reg <= tx_word;
			if (cmda_reg[`TXCB_A_LAST])
				in_packet_reg <= 1'b0;
		end
	end

	always_comb begin
		err_set = 1'b0;
		if (accept && state_reg == txcb_cmdb) begin
			if (!cmda_reg[`TXCB_A_FIRST] && tx_word != pkt_cmdb_reg)
				err_set = 1'b1;
			if (cmda_reg[`TXCB_A_LAST] && acc_now != {1'b0, tx_word[`TXCB_B_LEN_HI:0]})
				err_set = 1'b1;
		end
		if (st_valid && sts_full && !cfg_reg[`TXCB_CFG_ALLOW])
			err_set = 1'b1;
	end

	// Word walk through offset, payload and padding words
	always_ff @(posedge core_clk) begin
		if (srst) begin
			widx_reg       <= 11'h0;
			word_reg       <= 32'h0;
			lane_reg       <= 2'h0;
			end_lane_reg   <= 2'h0;
			word_final_reg <= 1'b0;
			buf_done_reg   <= 1'b0;
		end else if (accept && state_reg == txcb_cmdb) begin
			widx_reg <= 11'h0;
		end else if (accept && state_reg == txcb_data) begin
			widx_reg <= widx_reg + 11'h1;
			if (is_pay) begin
				word_reg     <= tx_word;
				lane_reg     <= (widx_reg == {8'h0, skipw}) ? lane0 : 2'h0;
				end_lane_reg <= (widx_reg == pay_end - 11'h1) ?
					2'(span - 13'h1) : 2'h3;
				word_final_reg <= (widx_reg == pay_end - 11'h1) && cmda_reg[`TXCB_A_LAST];
				buf_done_reg   <= last_word;
			end
		end else if (emit_step) begin
			lane_reg <= lane_reg + 2'h1;
		end
	end

	// Byte stream toward the MAC, held until taken
	always_ff @(posedge core_clk) begin
		if (srst) begin
			mac_byte       <= 8'h0;
			mac_byte_valid <= 1'b0;
			mac_byte_last  <= 1'b0;
			mac_no_crc     <= 1'b0;
			mac_no_pad     <= 1'b0;
			sent_tag_reg   <= 16'h0;
		end else if (emit_step) begin
			mac_byte       <= word_reg[{lane_reg, 3'h0} +: 8];
			mac_byte_valid <= 1'b1;
			mac_byte_last  <= word_final_reg && (lane_reg == end_lane_reg);
			mac_no_pad     <= pkt_cmdb_reg[`TXCB_B_NOPAD];
			mac_no_crc     <= pkt_cmdb_reg[`TXCB_B_NOCRC] &&
				!pkt_cmdb_reg[`TXCB_B_NOPAD];
			if (word_final_reg && lane_reg == end_lane_reg)
				sent_tag_reg <= pkt_cmdb_reg[31:`TXCB_B_TAG_LO];
		end else if (mac_byte_ready) begin
			mac_byte_valid <= 1'b0;
			mac_byte_last  <= 1'b0;
		end
	end

	// Status word assembly, reserved bits forced to zero
	assign es_bit = st_carrier_lost | st_no_carrier | st_late_collision |
		st_excess_collisions | (st_excess_deferral & cfg_reg[`TXCB_CFG_DEFCHK]);
	assign sts_word = {sent_tag_reg, es_bit, 3'h0,
		st_carrier_lost, st_no_carrier,
		st_late_collision,
		st_excess_collisions, 1'b0, st_collision_count,
		st_excess_deferral & cfg_reg[`TXCB_CFG_DEFCHK], 1'b0, st_deferred};

	assign sts_push = st_valid && !sts_full && !ovr_reg;
	assign sts_pop  = s_axi_arvalid && s_axi_arready &&
		(s_axi_araddr[11:0] == `TXCB_OFF_STS_DATA) && (count_reg != CW'(0));

	always_ff @(posedge core_clk) begin
		if (sts_push)
			sts_mem[wr_ptr_reg] <= sts_word;
	end

	always_ff @(posedge core_clk) begin
		if (srst) begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
			count_reg  <= '0;
		end else begin
			if (sts_push)
				wr_ptr_reg <= (wr_ptr_reg == PW'(STS_DEPTH - 1)) ? '0 : wr_ptr_reg + PW'(1);
			if (sts_pop)
				rd_ptr_reg <= (rd_ptr_reg == PW'(STS_DEPTH - 1)) ? '0 : rd_ptr_reg + PW'(1);
			if (sts_push && !sts_pop)
				count_reg <= count_reg + CW'(1);
			else if (sts_pop && !sts_push)
				count_reg <= count_reg - CW'(1);
		end
	end

	// Overrun latch; a new overrun in the pop cycle wins
	always_ff @(posedge core_clk) begin
		if (srst)
			ovr_reg <= 1'b0;
		else if (st_valid && sts_full && cfg_reg[`TXCB_CFG_ALLOW])
			ovr_reg <= 1'b1;
		else if (sts_pop)
			ovr_reg <= 1'b0;
	end

	// AXI4-Lite write side: address and data taken in either order
	assign do_write = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
	assign err_clr  = do_write && (awaddr_reg[11:0] == `TXCB_OFF_STAT) &&
		wstrb_reg[0] && wdata_reg[`TXCB_STAT_TXE];

	always_ff @(posedge core_clk) begin
		if (srst) begin
			s_axi_awready <= 1'b1;
			s_axi_wready  <= 1'b1;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= `TXCB_RESP_OKAY;
			awaddr_reg    <= '0;
			wdata_reg     <= 32'h0;
			wstrb_reg     <= 4'h0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				s_axi_awready <= 1'b0;
				awaddr_reg    <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				s_axi_wready <= 1'b0;
				wdata_reg    <= s_axi_wdata;
				wstrb_reg    <= s_axi_wstrb;
			end
			if (do_write) begin
				s_axi_bvalid  <= 1'b1;
				s_axi_bresp   <= txcb_mapped(awaddr_reg) ? `TXCB_RESP_OKAY : `TXCB_RESP_SLVERR;
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid  <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready  <= 1'b1;
			end
		end
	end

	always_ff @(posedge core_clk) begin
		if (srst)
			cfg_reg <= `TXCB_CFG_RST;
		else if (do_write && awaddr_reg[11:0] == `TXCB_OFF_CFG && wstrb_reg[0])
			cfg_reg <= wdata_reg[1:0];
	end

	// Error flag: a new error in the clearing cycle survives
	always_ff @(posedge core_clk) begin
		if (srst)
			transmit_error_flag <= 1'b0;
		else
			transmit_error_flag <= (transmit_error_flag && !err_clr) || err_set;
	end

	// AXI4-Lite read side, one outstanding read
	always_ff @(posedge core_clk) begin
		if (srst) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h0;
			s_axi_rresp   <= `TXCB_RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b1;
			s_axi_rresp   <= txcb_mapped(s_axi_araddr) ? `TXCB_RESP_OKAY : `TXCB_RESP_SLVERR;
			unique case (s_axi_araddr[11:0])
				`TXCB_OFF_CFG:  s_axi_rdata <= {30'h0, cfg_reg};
				`TXCB_OFF_STAT: s_axi_rdata <= {30'h0, ovr_reg, transmit_error_flag};
				`TXCB_OFF_STS_DATA:
					s_axi_rdata <= (count_reg != CW'(0)) ? sts_mem[rd_ptr_reg] : 32'h0;
				`TXCB_OFF_STS_USED:
					s_axi_rdata <= ovr_reg ? 32'h0 : 32'(count_reg);
				default: s_axi_rdata <= 32'h0;
			endcase
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid  <= 1'b0;
			s_axi_arready <= 1'b1;
		end
	end

endmodule

// *** tb/txcb_host_model.sv ***
// Host CPU model feeding command and buffer words into the block
`timescale 1ns/1ps

module txcb_host_model (
	input wire logic  core_clk,
	output logic [31:0] tx_word,
	output logic        tx_word_valid,
	input wire logic    tx_word_ready
);
	initial begin
		tx_word = 32'h0;
		tx_word_valid = 1'b0;
	end
	// Called just after a rising edge; returns just after the taking edge
	task put(input logic [31:0] w);
		tx_word <= w;
		tx_word_valid <= 1'b1;
		do @(posedge core_clk); while (!tx_word_ready);
	endtask
	// Byte p of a buffer carries base+p, so the bench can predict every lane
	task send_buf(input logic [31:0] a, input logic [31:0] b, input logic [7:0] base);
		int al;
		int n;
		al = (a[25:24] == 2'h1) ? 16 : (a[25:24] == 2'h2) ? 32 : 4;
		n = ((int'(a[20:16]) + int'(a[10:0]) + al - 1) / al) * al / 4;
		put(a);
		put(b);
		for (int i = 0; i < n; i++)
			put({8'(base + 4 * i + 3), 8'(base + 4 * i + 2), 8'(base + 4 * i + 1), 8'(base + 4 * i)});
		tx_word_valid <= 1'b0;
		// Released line shows the inverse so a stale word cannot look valid
		tx_word <= ~tx_word;
		// Idle edge so a following buffer never re-raises valid in this step
		@(posedge core_clk);
	endtask
endmodule

// *** tb/txcb_props.sv ***
// Port-level assertions for the transmit command buffer block
`timescale 1ns/1ps

module txcb_props #(
	parameter int STS_DEPTH = 16
) (
	input wire logic        core_clk,
	input wire logic        srst,
	input wire logic        s_axi_awvalid,
	input wire logic        s_axi_awready,
	input wire logic        s_axi_wvalid,
	input wire logic        s_axi_wready,
	input wire logic [1:0]  s_axi_bresp,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_bready,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0]  s_axi_rresp,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready,
	input wire logic [7:0]  mac_byte,
	input wire logic        mac_byte_valid,
	input wire logic        mac_byte_last,
	input wire logic        mac_no_crc,
	input wire logic        mac_no_pad,
	input wire logic        mac_byte_ready
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (srst);
	property p_wr_ans;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid;
	endproperty
	a_wr_ans: assert property (p_wr_ans) else $error("write response late");
	property p_b_hold;
		s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
	endproperty
	a_b_hold: assert property (p_b_hold) else $error("write response dropped");
	property p_b_block;
		s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
	endproperty
	a_b_block: assert property (p_b_block) else $error("new write taken early");
	property p_rd_ans;
		s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready;
	endproperty
	a_rd_ans: assert property (p_rd_ans) else $error("read data late");
	property p_r_hold;
		s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
	endproperty
	a_r_hold: assert property (p_r_hold) else $error("read data dropped");
	property p_r_err;
		s_axi_rvalid && s_axi_rresp == 2'h2 |-> s_axi_rdata == 32'h0;
	endproperty
	a_r_err: assert property (p_r_err) else $error("error read carries data");
	property p_mac_hold;
		mac_byte_valid && !mac_byte_ready |=> mac_byte_valid
			&& $stable({mac_byte, mac_byte_last, mac_no_crc, mac_no_pad});
	endproperty
	a_mac_hold: assert property (p_mac_hold) else $error("byte changed while stalled");
	property p_crc_pad;
		mac_byte_valid && mac_no_pad |-> !mac_no_crc;
	endproperty
	a_crc_pad: assert property (p_crc_pad) else $error("crc dropped with padding off");
	c_last: cover property (mac_byte_valid && mac_byte_ready && mac_byte_last);
	c_rerr: cover property (s_axi_rvalid && s_axi_rresp == 2'h2);
	c_stall: cover property (mac_byte_valid && !mac_byte_ready);
endmodule

bind txcb_top txcb_props #(.STS_DEPTH(STS_DEPTH)) u_txcb_props (.core_clk, .srst,
	.s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
	.s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
	.s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .mac_byte, .mac_byte_valid,
	.mac_byte_last, .mac_no_crc, .mac_no_pad, .mac_byte_ready);

// *** tb/txcb_top_tb.sv ***
// Self-checking bench for the transmit command buffer block
`timescale 1ns/1ps
`include "txcb_map.svh"

module txcb_top_tb;
	logic        core_clk, srst, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic [11:0] s_axi_awaddr, s_axi_araddr;
	logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
	logic        s_axi_rready, tx_word_valid, tx_word_ready, mac_byte_valid, mac_byte_last;
	logic [31:0] s_axi_wdata, s_axi_rdata, tx_word;
	logic [3:0]  s_axi_wstrb, st_collision_count;
	logic [1:0]  s_axi_bresp, s_axi_rresp, r;
	logic [7:0]  mac_byte, cyc;
	logic        mac_no_crc, mac_no_pad, mac_byte_ready, st_valid, st_carrier_lost;
	logic        st_no_carrier, st_late_collision, st_excess_collisions, st_excess_deferral;
	logic        st_deferred, transmit_error_flag;
	logic [10:0] exq[$], cap[$];
	logic [9:0]  fs[4] = '{10'h217, 10'h1fc, 10'h003, 10'h024};
	int          failures = 0, check_count = 0;

	txcb_top #(.STS_DEPTH(4)) u_txcb_top (.core_clk, .srst, .s_axi_awaddr, .s_axi_awvalid,
		.s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
		.s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
		.s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .tx_word,
		.tx_word_valid, .tx_word_ready, .mac_byte, .mac_byte_valid, .mac_byte_last,
		.mac_no_crc, .mac_no_pad, .mac_byte_ready, .st_valid, .st_carrier_lost,
		.st_no_carrier, .st_late_collision, .st_excess_collisions, .st_collision_count,
		.st_excess_deferral, .st_deferred, .transmit_error_flag);
	txcb_host_model u_txcb_host_model (.core_clk, .tx_word, .tx_word_valid, .tx_word_ready);

	always #2 core_clk = ~core_clk;
	// Ready stalls one cycle in four so every byte must survive back-pressure
	always @(posedge core_clk) begin
		cyc <= cyc + 8'h1;
		mac_byte_ready <= cyc[1:0] != 2'h3;
		if (!srst && mac_byte_valid && mac_byte_ready)
			cap.push_back({mac_byte_last, mac_no_crc, mac_no_pad, mac_byte});
	end

	task print_verdict;
		if (failures == 0 && check_count > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	task chk(input string n, input logic [31:0] e, input logic [31:0] g);
		check_count++;
		if (g !== e) begin
			failures++;
			$display("Error %s expected %h seen %h", n, e, g);
		end
	endtask
	task wr(input logic [11:0] a, input logic [31:0] d, output logic [1:0] rs);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge core_clk);
			if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (!(s_axi_bvalid && s_axi_bready));
		rs = s_axi_bresp;
		s_axi_bready <= 1'b0;
		@(posedge core_clk);
	endtask
	task rc(input logic [11:0] a, input logic [31:0] e, input logic [1:0] er);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge core_clk);
			if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (!(s_axi_rvalid && s_axi_rready));
		chk("rdata", e, s_axi_rdata);
		chk("rresp", 32'(er), 32'(s_axi_rresp));
		s_axi_rready <= 1'b0;
		@(posedge core_clk);
	endtask
	function logic [31:0] ca(input logic [1:0] al, input logic [4:0] o, input logic f,
		input logic l, input logic [10:0] sz);
		return {6'h0, al, 3'h0, o, 2'h0, f, l, 1'b0, sz};
	endfunction
	function logic [31:0] cb(input logic [15:0] t, input logic nc, input logic np,
		input logic [10:0] len);
		return {t, 2'h0, nc, np, 1'b0, len};
	endfunction
	function logic [31:0] sw(input logic [15:0] t, input logic [9:0] f, input logic d);
		return {t, |f[9:6] | (f[1] & d), 3'h0, f[9:6], 1'b0, f[5:2], f[1] & d, 1'b0, f[0]};
	endfunction
	task sb(input logic [31:0] a, input logic [31:0] b, input logic [7:0] base);
		for (int k = 0; k < int'(a[10:0]); k++)
			exq.push_back({a[12] && k == int'(a[10:0]) - 1, b[13] & !b[12], b[12],
				8'(base + a[20:16] + k)});
		u_txcb_host_model.send_buf(a, b, base);
	endtask
	task pd;
		while (cap.size() < exq.size()) @(posedge core_clk);
		repeat (6) @(posedge core_clk);
		chk("byte count", exq.size(), cap.size());
		foreach (exq[i]) chk("mac byte", 32'(exq[i]), 32'(cap[i]));
		exq.delete();
		cap.delete();
	endtask
	task stp(input logic [9:0] f);
		@(posedge core_clk);
		{st_carrier_lost, st_no_carrier, st_late_collision, st_excess_collisions,
			st_collision_count, st_excess_deferral, st_deferred} <= f;
		st_valid <= 1'b1;
		@(posedge core_clk);
		st_valid <= 1'b0;
	endtask

	initial begin
		{core_clk, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata, cyc, st_valid, mac_byte_ready} = 0;
		{st_carrier_lost, st_no_carrier, st_late_collision, st_excess_collisions} = 0;
		{st_collision_count, st_excess_deferral, st_deferred} = 0;
		s_axi_wstrb = 4'hf;
		srst = 1'b1;
		repeat (3) @(posedge core_clk);
		srst <= 1'b0;
		@(posedge core_clk);
		rc(`TXCB_OFF_CFG, 32'h0, `TXCB_RESP_OKAY);
		rc(12'h010, 32'h0, `TXCB_RESP_SLVERR);
		wr(12'h010, 32'h3, r);
		chk("bresp", 32'(`TXCB_RESP_SLVERR), 32'(r));
		sb(ca(2'h0, 5'd1, 1'b1, 1'b1, 11'd3), cb(16'hbeef, 1'b1, 1'b0, 11'd3), 8'h00);
		pd();
		sb(ca(2'h1, 5'd5, 1'b1, 1'b1, 11'd2) | 32'h0080_c800, cb(16'h1234, 1'b1, 1'b1, 11'd2),
			8'h40);
		pd();
		for (int j = 0; j < 2; j++) begin
			sb(ca(2'h0, 5'd3, 1'b1, 1'b0, 11'd6), cb(16'h5a5a, 1'b0, 1'b0, 11'd11), 8'h80);
			sb(ca(2'h2, 5'd31, 1'b0, 1'b1, 11'd5), cb(16'h5a5a ^ 16'(j), 1'b0, 1'b0, 11'd11),
				8'h00);
			pd();
			rc(`TXCB_OFF_STAT, 32'(j), `TXCB_RESP_OKAY);
		end
		wr(`TXCB_OFF_STAT, 32'h1, r);
		rc(`TXCB_OFF_STAT, 32'h0, `TXCB_RESP_OKAY);
		sb(ca(2'h0, 5'd0, 1'b1, 1'b1, 11'd3), cb(16'h7777, 1'b0, 1'b0, 11'd4), 8'h10);
		pd();
		rc(`TXCB_OFF_STAT, 32'h1, `TXCB_RESP_OKAY);
		chk("error flag", 32'h1, 32'(transmit_error_flag));
		wr(`TXCB_OFF_STAT, 32'h1, r);
		for (int i = 0; i < 4; i++) begin
			if (i == 2) wr(`TXCB_OFF_CFG, 32'h2, r);
			stp(fs[i]);
		end
		rc(`TXCB_OFF_STS_USED, 32'h4, `TXCB_RESP_OKAY);
		stp(fs[3]);
		chk("word ready", 32'h0, 32'(tx_word_ready));
		rc(`TXCB_OFF_STAT, 32'h1, `TXCB_RESP_OKAY);
		wr(`TXCB_OFF_STAT, 32'h1, r);
		wr(`TXCB_OFF_CFG, 32'h3, r);
		chk("bresp", 32'(`TXCB_RESP_OKAY), 32'(r));
		stp(fs[3]);
		rc(`TXCB_OFF_STS_USED, 32'h0, `TXCB_RESP_OKAY);
		chk("word ready", 32'h1, 32'(tx_word_ready));
		rc(`TXCB_OFF_STAT, 32'h2, `TXCB_RESP_OKAY);
		for (int i = 0; i < 4; i++)
			rc(`TXCB_OFF_STS_DATA, sw(16'h7777, fs[i], i > 1), `TXCB_RESP_OKAY);
		rc(`TXCB_OFF_STS_DATA, 32'h0, `TXCB_RESP_OKAY);
		rc(`TXCB_OFF_CFG, 32'h3, `TXCB_RESP_OKAY);
		print_verdict();
	end
	initial begin
		repeat (20000) @(posedge core_clk);
		failures++;
		print_verdict();
	end
endmodule
